// ===== hw/touch_link_pkg.sv
// constants, field layouts and carrier types for the touch key mode and status link
// assumes a single 250 MHz clock and a classic wishbone register bus
package touch_link_pkg;

  // ************************************************************
  // sizing and clock rates
  // ************************************************************
  // four-key variant: serial link plus level-hold or toggle outputs
  localparam int unsigned KEY_COUNT = 4;
  localparam int unsigned BIT_IDX_W = 2;
  localparam int unsigned CLK_HZ = 250_000_000;
  localparam int unsigned LINE_CLK_HZ = 13_000;
  localparam int unsigned HALF_LINE_CYC = CLK_HZ / (2 * LINE_CLK_HZ);
  localparam int unsigned MS_PER_S = 1000;
  localparam int unsigned MS_CYC = CLK_HZ / MS_PER_S;

  // ************************************************************
  // key timing, in milliseconds (one ms tick each)
  // ************************************************************
  localparam logic [15:0] RESP_NORMAL_MS = 16'h0064;  // 100 ms
  localparam logic [15:0] RESP_STANDBY_MS = 16'h0190; // 400 ms
  localparam logic [15:0] HOLD_MS = 16'h9c40;         // 40 s
  localparam logic [15:0] CAL_NORMAL_MS = 16'h09c4;   // 2.5 s
  localparam logic [15:0] CAL_STANDBY_MS = 16'h2710;  // 10 s
  localparam logic [15:0] NORMAL_ON_MS = 16'h4e20;    // 20 s

  // ************************************************************
  // link timing, in line clock periods and half periods
  // ************************************************************
  localparam int unsigned LINE_PERIOD_US = 76;
  localparam int unsigned REQ_WIN_US = 152;
  localparam int unsigned REQ_WIN_TSCD = REQ_WIN_US / LINE_PERIOD_US;
  localparam int unsigned SYNC_LO_TSCD = 2;
  localparam int unsigned SYNC_HI_TSCD = 2;
  localparam int unsigned BIT_TSCD = 4;
  localparam int unsigned CMD_LOW_TSCD = 8;
  localparam int unsigned CMD_WIN_TSCD = 4;
  localparam logic [4:0] REQ_WIN_HT = 5'(2 * REQ_WIN_TSCD);
  localparam logic [4:0] SYNC_LO_HT = 5'(2 * SYNC_LO_TSCD);
  localparam logic [4:0] SYNC_HI_HT = 5'(2 * SYNC_HI_TSCD);
  localparam logic [4:0] BIT_HT = 5'(2 * BIT_TSCD);
  localparam logic [4:0] CMD_LOW_HT = 5'(2 * CMD_LOW_TSCD);
  localparam logic [4:0] CMD_WIN_HT = 5'(2 * CMD_WIN_TSCD);
  localparam logic [4:0] REQ_EDGES = 5'h03;
  localparam logic [4:0] EDGE_MAX = 5'h1f;

  // command pulse count thresholds
  localparam logic [4:0] CMD_ONE_MIN = 5'h03;
  localparam logic [4:0] CMD_TEST_MIN = 5'h07;
  localparam logic [4:0] CMD_ANY_MIN = 5'h0b;
  localparam logic [4:0] CMD_ANY_MAX = 5'h0e;
  localparam logic [4:0] CMD_ALWAYS_MIN = 5'h10;

  // ************************************************************
  // register map and fields
  // ************************************************************
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_CMD = 8'h08;
  localparam int unsigned CTRL_LINK_EN_BIT = 0;
  localparam int unsigned CTRL_RECAL_BIT = 1;
  localparam logic CTRL_LINK_EN_RST = 1'b1;
  localparam int unsigned ST_KEY_POS = 0;
  localparam int unsigned ST_OUT_POS = 4;
  localparam int unsigned ST_NORMAL_BIT = 8;
  localparam int unsigned ST_CFG_POS = 9;
  localparam int unsigned ST_TOGGLE_BIT = 11;
  localparam int unsigned ST_PIN_ANY_BIT = 12;
  localparam int unsigned ST_LINK_POS = 13;
  localparam logic [1:0] STRAP_WAIT = 2'h3;

  // ************************************************************
  // types
  // ************************************************************
  typedef enum logic [3:0] {
    L_IDLE = 4'h0, L_REQ = 4'h1, L_SYNC_LO = 4'h3, L_SYNC_HI = 4'h2,
    L_DATA = 4'h6, L_NOTIFY = 4'h4, L_TAIL = 4'h5,
    L_CMD_LOW = 4'h8, L_CMD_WIN = 4'h9, L_CMD_END = 4'hb
  } link_state_t;

  typedef enum logic [1:0] {
    CFG_PIN = 2'h0, CFG_ONE = 2'h1, CFG_ANY = 2'h3, CFG_ALWAYS = 2'h2
  } wake_cfg_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } wb_rsp_t;

endpackage : touch_link_pkg

// ===== hw/sync_bits.sv
// two flip-flop synchroniser for a group of asynchronous inputs
// assumes each bit is a slow level; no bus coherency across bits
`timescale 1ns/1ps
`default_nettype none
module sync_bits #(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_state_t;

  sync_state_t st_r;
  sync_state_t st_nxt;

  always_comb begin
    st_nxt.s1 = d_i;
    st_nxt.s2 = st_r.s1;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= {RST_VAL, RST_VAL};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q_o = st_r.s2;
endmodule : sync_bits
`default_nettype wire

// ===== hw/pulse_div.sv
// clock divider giving a one-cycle enable every DIV cycles
// assumes DIV >= 2; clr_i restarts the period so events align to it
`timescale 1ns/1ps
`default_nettype none
module pulse_div #(
  parameter int unsigned DIV = 2
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic clr_i,
  output logic tick_o
);
  localparam int unsigned CW = $clog2(DIV);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic tick;
  } div_state_t;

  div_state_t st_r;
  div_state_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.tick = 1'b0;
    if (clr_i) begin
      st_nxt.cnt = '0;
    end else if (st_r.cnt == CW'(DIV - 1)) begin
      st_nxt.cnt = '0;
      st_nxt.tick = 1'b1;
    end else begin
      st_nxt.cnt = st_r.cnt + CW'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign tick_o = st_r.tick;
endmodule : pulse_div
`default_nettype wire

// ===== hw/touch_key_link.sv
// touch key mode control, key output stage and single-wire host link
// assumes key_det_i comes from a sensing front end, pins and line are async
//
// Local design decisions: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module touch_key_link #(
  parameter int unsigned HALF_LINE_DIV = touch_link_pkg::HALF_LINE_CYC,
  parameter int unsigned MS_DIV = touch_link_pkg::MS_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire touch_link_pkg::wb_req_t wb_req_i,
  output var touch_link_pkg::wb_rsp_t wb_rsp_o,
  input wire logic [touch_link_pkg::KEY_COUNT-1:0] key_det_i,
  input wire logic wake_select_pin_i,
  input wire logic output_type_pin_i,
  input wire logic shared_line_i,
  output logic shared_line_o,
  output logic shared_line_oe_o,
  output logic [touch_link_pkg::KEY_COUNT-1:0] key_out_o,
  output logic [touch_link_pkg::KEY_COUNT-1:0] cal_req_o,
  output logic normal_mode_o,
  output logic suspended_o
);
  import touch_link_pkg::*;

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic [1:0] strap_cnt;
    logic strapped;
    logic pin_any;
    logic pin_toggle;
    wake_cfg_t cfg;
    logic normal;
    logic [KEY_COUNT-1:0] raw_prev;
    logic [KEY_COUNT-1:0] key_db;
    logic [KEY_COUNT-1:0] key_out;
    logic [KEY_COUNT-1:0] key_block;
    logic [KEY_COUNT-1:0] cal;
    logic [15:0] deb_cnt;
    logic [15:0] hold_cnt;
    logic [15:0] idle_cnt;
    logic [15:0] cal_cnt;
    link_state_t lst;
    logic [4:0] ht_cnt;
    logic [4:0] edge_cnt;
    logic [4:0] last_cmd;
    logic line_prev;
    logic [BIT_IDX_W-1:0] bit_idx;
    logic [KEY_COUNT-1:0] shift;
    logic drv;
    logic drv_val;
    logic notify_pend;
    logic link_en;
    logic ack;
    logic [31:0] dat;
  } state_t;

  localparam logic [KEY_COUNT-1:0] FIRST_KEY = KEY_COUNT'(1);
  localparam logic [BIT_IDX_W-1:0] LAST_BIT = BIT_IDX_W'(KEY_COUNT - 1);

  state_t r;
  state_t n;
  logic [KEY_COUNT+2:0] sync_q;
  logic [KEY_COUNT-1:0] key_s;
  logic line_s;
  logic wake_s;
  logic type_s;
  logic ht_tick;
  logic ht_clr;
  logic ms_tick;
  logic always_n;
  logic any_wake;
  logic suspend;
  logic [KEY_COUNT-1:0] raw_m;
  logic [15:0] resp_ms;
  logic [15:0] cal_ms;

  // ************************************************************
  // pin synchronisers and rate enables
  // ************************************************************
  sync_bits #(
    .W(KEY_COUNT + 3),
    .RST_VAL({3'h7, {KEY_COUNT{1'b0}}})
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i({shared_line_i, wake_select_pin_i, output_type_pin_i, key_det_i}),
    .q_o(sync_q)
  );

  assign key_s = sync_q[KEY_COUNT-1:0];
  assign type_s = sync_q[KEY_COUNT];
  assign wake_s = sync_q[KEY_COUNT+1];
  assign line_s = sync_q[KEY_COUNT+2];

  // half line clock enable, restarted so link frames align to it
  pulse_div #(.DIV(HALF_LINE_DIV)) u_half_line (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clr_i(ht_clr),
    .tick_o(ht_tick)
  );

  pulse_div #(.DIV(MS_DIV)) u_ms (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clr_i(1'b0),
    .tick_o(ms_tick)
  );

  // ************************************************************
  // mode helpers
  // ************************************************************
  function automatic wake_cfg_t cmd_decode(input logic [4:0] cnt, input wake_cfg_t cur);
    if (cnt < CMD_ONE_MIN) begin
      cmd_decode = CFG_PIN;
    end else if (cnt < CMD_TEST_MIN) begin
      cmd_decode = CFG_ONE;
    end else if (cnt < CMD_ANY_MIN) begin
      cmd_decode = cur;
    end else if (cnt <= CMD_ANY_MAX) begin
      cmd_decode = CFG_ANY;
    end else if (cnt >= CMD_ALWAYS_MIN) begin
      cmd_decode = CFG_ALWAYS;
    end else begin
      cmd_decode = cur;
    end
  endfunction : cmd_decode

  assign always_n = (r.cfg == CFG_ALWAYS);
  assign any_wake = (r.cfg == CFG_ANY) || ((r.cfg == CFG_PIN) && r.pin_any);
  assign suspend = (r.lst == L_CMD_LOW) || (r.lst == L_CMD_WIN) || (r.lst == L_CMD_END);
  // in one-key standby only the first key can wake the device
  assign raw_m = (r.normal || any_wake) ? key_s : (key_s & FIRST_KEY);
  assign resp_ms = r.normal ? RESP_NORMAL_MS : RESP_STANDBY_MS;
  assign cal_ms = r.normal ? CAL_NORMAL_MS : CAL_STANDBY_MS;

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    logic rise;
    logic [KEY_COUNT-1:0] det;
    logic [31:0] rd;
    wake_cfg_t newcfg;
    rise = line_s & ~r.line_prev;
    det = '0;
    rd = '0;
    newcfg = r.cfg;
    n = r;
    n.cal = '0;
    n.line_prev = line_s;
    ht_clr = 1'b0;

    // power-on strap capture, a few cycles after reset release
    if (!r.strapped) begin
      n.strap_cnt = r.strap_cnt + 2'h1;
      if (r.strap_cnt == STRAP_WAIT) begin
        n.strapped = 1'b1;
        n.pin_any = ~wake_s;
        n.pin_toggle = ~type_s;
        n.cal = '1;
      end
    end

    // single-wire link
    if (!r.link_en) begin
      n.lst = L_IDLE;
      n.drv = 1'b0;
      n.ht_cnt = '0;
    end else begin
      unique case (r.lst)
        L_IDLE: begin
          n.drv = 1'b0;
          if (rise) begin
            n.lst = L_REQ;
            n.edge_cnt = 5'h01;
            n.ht_cnt = '0;
            ht_clr = 1'b1;
          end else if (!line_s) begin
            if (ht_tick) begin
              if (r.ht_cnt == CMD_LOW_HT) begin
                n.lst = L_CMD_LOW;
              end else begin
                n.ht_cnt = r.ht_cnt + 5'h01;
              end
            end
          end else begin
            n.ht_cnt = '0;
            if (r.notify_pend) begin
              n.lst = L_NOTIFY;
              n.drv = 1'b1;
              n.drv_val = 1'b0;
              n.notify_pend = 1'b0;
              ht_clr = 1'b1;
            end
          end
        end
        L_NOTIFY: begin
          if (ht_tick) begin
            n.lst = L_TAIL;
            n.drv_val = 1'b1;
          end
        end
        // drive high briefly so our own release is not taken as a host edge
        L_TAIL: begin
          if (ht_tick) begin
            n.lst = L_IDLE;
            n.drv = 1'b0;
            n.ht_cnt = '0;
          end
        end
        L_REQ: begin
          if (rise && (r.edge_cnt != EDGE_MAX)) begin
            n.edge_cnt = r.edge_cnt + 5'h01;
          end
          if (ht_tick) begin
            if (r.ht_cnt == REQ_WIN_HT - 5'h01) begin
              n.ht_cnt = '0;
              if (r.edge_cnt >= REQ_EDGES) begin
                n.lst = L_SYNC_LO;
                n.drv = 1'b1;
                n.drv_val = 1'b0;
                n.shift = ~r.key_db;
                n.bit_idx = '0;
              end else begin
                n.lst = L_IDLE;
              end
            end else begin
              n.ht_cnt = r.ht_cnt + 5'h01;
            end
          end
        end
        L_SYNC_LO: begin
          if (ht_tick) begin
            if (r.ht_cnt == SYNC_LO_HT - 5'h01) begin
              n.lst = L_SYNC_HI;
              n.drv_val = 1'b1;
              n.ht_cnt = '0;
            end else begin
              n.ht_cnt = r.ht_cnt + 5'h01;
            end
          end
        end
        L_SYNC_HI: begin
          if (ht_tick) begin
            if (r.ht_cnt == SYNC_HI_HT - 5'h01) begin
              n.lst = L_DATA;
              n.drv_val = r.shift[0];
              n.ht_cnt = '0;
            end else begin
              n.ht_cnt = r.ht_cnt + 5'h01;
            end
          end
        end
        L_DATA: begin
          if (ht_tick) begin
            if (r.ht_cnt == BIT_HT - 5'h01) begin
              n.ht_cnt = '0;
              if (r.bit_idx == LAST_BIT) begin
                n.lst = L_TAIL;
                n.drv_val = 1'b1;
              end else begin
                n.bit_idx = r.bit_idx + BIT_IDX_W'(1);
                n.shift = r.shift >> 1;
                n.drv_val = r.shift[1];
              end
            end else begin
              n.ht_cnt = r.ht_cnt + 5'h01;
            end
          end
        end
        L_CMD_LOW: begin
          if (rise) begin
            n.lst = L_CMD_WIN;
            n.ht_cnt = '0;
            n.edge_cnt = '0;
            ht_clr = 1'b1;
          end
        end
        L_CMD_WIN: begin
          if (rise && (r.edge_cnt != EDGE_MAX)) begin
            n.edge_cnt = r.edge_cnt + 5'h01;
          end
          if (ht_tick) begin
            if (r.ht_cnt == CMD_WIN_HT - 5'h01) begin
              n.lst = L_CMD_END;
            end else begin
              n.ht_cnt = r.ht_cnt + 5'h01;
            end
          end
        end
        L_CMD_END: begin
          if (line_s) begin
            newcfg = cmd_decode(r.edge_cnt, r.cfg);
            n.cfg = newcfg;
            n.last_cmd = r.edge_cnt;
            n.lst = L_IDLE;
            n.ht_cnt = '0;
            if (newcfg == CFG_ALWAYS) begin
              n.normal = 1'b1;
            end
          end
        end
        default: begin
          n.lst = L_IDLE;
          n.drv = 1'b0;
        end
      endcase
    end

    // key processing, frozen while a command is being taken
    if (r.strapped && !suspend) begin
      if (ms_tick) begin
        n.idle_cnt = r.idle_cnt + 16'h0001;
        n.cal_cnt = r.cal_cnt + 16'h0001;
        if (r.normal && !always_n && (r.idle_cnt >= NORMAL_ON_MS - 16'h0001)) begin
          n.normal = 1'b0;
          n.idle_cnt = '0;
        end
        if (r.cal_cnt >= cal_ms - 16'h0001) begin
          n.cal = ~r.key_db;
          n.cal_cnt = '0;
        end
        if (|(r.key_db & ~r.key_block)) begin
          n.hold_cnt = r.hold_cnt + 16'h0001;
          if (r.hold_cnt >= HOLD_MS - 16'h0001) begin
            n.key_block = r.key_db;
            n.key_out = '0;
            n.normal = always_n;
            n.cal = '1;
            n.hold_cnt = '0;
            n.idle_cnt = '0;
            n.cal_cnt = '0;
          end
        end else begin
          n.hold_cnt = '0;
        end
      end
      if (raw_m != r.raw_prev) begin
        n.raw_prev = raw_m;
        n.deb_cnt = '0;
      end else if (ms_tick) begin
        if (r.deb_cnt < resp_ms - 16'h0001) begin
          n.deb_cnt = r.deb_cnt + 16'h0001;
        end else if (r.raw_prev != r.key_db) begin
          det = r.raw_prev & ~r.key_db & ~r.key_block;
          n.key_db = r.raw_prev;
          n.key_block = r.key_block & r.raw_prev;
          if (r.pin_toggle) begin
            n.key_out = r.key_out ^ det;
          end else begin
            n.key_out = r.raw_prev & ~n.key_block;
          end
          if (|det) begin
            n.normal = 1'b1;
            n.idle_cnt = '0;
            n.cal_cnt = '0;
            n.hold_cnt = '0;
          end
        end
      end
    end
    // a change in the same cycle as the pulse start is kept pending
    if (n.key_db != r.key_db) begin
      n.notify_pend = 1'b1;
    end

    // wishbone slave, one wait state, unmapped reads return zero
    rd[ST_KEY_POS +: KEY_COUNT] = r.key_db;
    rd[ST_OUT_POS +: KEY_COUNT] = r.key_out;
    rd[ST_NORMAL_BIT] = r.normal;
    rd[ST_CFG_POS +: 2] = r.cfg;
    rd[ST_TOGGLE_BIT] = r.pin_toggle;
    rd[ST_PIN_ANY_BIT] = r.pin_any;
    rd[ST_LINK_POS +: 4] = r.lst;
    n.ack = wb_req_i.cyc & wb_req_i.stb & ~r.ack;
    if (n.ack) begin
      n.dat = '0;
      unique case (wb_req_i.adr)
        REG_CTRL: begin
          n.dat[CTRL_LINK_EN_BIT] = r.link_en;
          if (wb_req_i.we && wb_req_i.sel[0]) begin
            n.link_en = wb_req_i.dat[CTRL_LINK_EN_BIT];
            if (wb_req_i.dat[CTRL_RECAL_BIT]) begin
              n.cal = '1;
            end
          end
        end
        REG_STATUS: n.dat = rd;
        REG_CMD: n.dat[4:0] = r.last_cmd;
        default: n.dat = '0;
      endcase
    end
  end

  // ************************************************************
  // registers and outputs
  // ************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r <= '0;
      r.line_prev <= 1'b1;  // line idles high; a zero here reads as a host edge
      r.lst <= L_IDLE;
      r.cfg <= CFG_PIN;
      r.link_en <= CTRL_LINK_EN_RST;
    end else begin
      r <= n;
    end
  end

  assign shared_line_o = r.drv_val;
  assign shared_line_oe_o = r.drv;
  assign key_out_o = r.key_out;
  assign cal_req_o = r.cal;
  assign normal_mode_o = r.normal;
  assign suspended_o = suspend;
  assign wb_rsp_o.ack = r.ack;
  assign wb_rsp_o.dat = r.dat;
endmodule : touch_key_link
`default_nettype wire

// ===== test/touch_key_link_sva.sv
// port checks for the touch key block
// assumes it is bound into every touch_key_link instance
`timescale 1ns/1ps
`default_nettype none
module touch_key_link_sva (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire touch_link_pkg::wb_req_t wb_req_i,
  input wire touch_link_pkg::wb_rsp_t wb_rsp_o,
  input wire logic shared_line_o,
  input wire logic shared_line_oe_o,
  input wire logic [touch_link_pkg::KEY_COUNT-1:0] cal_req_o,
  input wire logic normal_mode_o,
  input wire logic suspended_o
);
  import touch_link_pkg::*;
  // ****
  // relations
  // ****
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_ack_taken:
    assert property (wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack |=> wb_rsp_o.ack)
    else $error("request not acknowledged");
  chk_ack_single: assert property (wb_rsp_o.ack |=> !wb_rsp_o.ack)
    else $error("ack longer than one cycle");
  chk_unmapped_zero: assert property (wb_rsp_o.ack && wb_req_i.adr == 8'h0c |-> wb_rsp_o.dat == '0)
    else $error("unmapped read not zero");
  chk_drive_low: assert property ($rose(shared_line_oe_o) |-> (!shared_line_o) [*8])
    else $error("drive does not open low");
  chk_high_release: assert property ($fell(shared_line_oe_o) |-> $past(shared_line_o))
    else $error("line released while low");
  chk_susp_quiet: assert property (suspended_o |-> !shared_line_oe_o)
    else $error("line driven during command");
  chk_standby_start: assert property ($fell(rst_i) |-> (!normal_mode_o) [*8])
    else $error("normal mode right after reset");
  chk_power_cal: assert property ($fell(rst_i) |-> ##[1:8] (cal_req_o == 4'hf))
    else $error("no calibration after reset");
endmodule : touch_key_link_sva
bind touch_key_link touch_key_link_sva u_sva (.clk_i(clk_i), .rst_i(rst_i),
  .wb_req_i(wb_req_i), .wb_rsp_o(wb_rsp_o), .shared_line_o(shared_line_o),
  .shared_line_oe_o(shared_line_oe_o), .cal_req_o(cal_req_o),
  .normal_mode_o(normal_mode_o), .suspended_o(suspended_o));
`default_nettype wire

// ===== test/host_model.sv
// host at the far end of the shared line
// assumes the bench resolves the pulled-up wire from low_o and the device
`timescale 1ns/1ps
`default_nettype none
module host_model #(
  parameter int unsigned HT = 20
) (
  input wire logic clk_i,
  input wire logic line_i,
  output logic low_o
);
  // ****
  // line driving
  // ****
  initial low_o = 1'b0;
  task automatic pulses(input int n, input int w);
    repeat (n) begin
      @(posedge clk_i);
      low_o <= 1'b1;
      repeat (w) @(posedge clk_i);
      low_o <= 1'b0;
      repeat (w - 1) @(posedge clk_i);
    end
  endtask : pulses
  task automatic request();
    pulses(3, 5);
  endtask : request
  task automatic command(input int n);
    @(posedge clk_i);
    low_o <= 1'b1;
    repeat (18 * HT) @(posedge clk_i);
    low_o <= 1'b0;
    repeat (4) @(posedge clk_i);
    pulses(n, 4);
  endtask : command
  // align on the sync fall, then sample mid-bit away from the edges
  task automatic read(output logic [3:0] d);
    @(negedge line_i);
    repeat (12 * HT) @(posedge clk_i);
    for (int i = 0; i < 4; i++) begin
      d[i] = line_i;
      repeat (8 * HT) @(posedge clk_i);
    end
  endtask : read
endmodule : host_model
`default_nettype wire

// ===== test/touch_key_link_tb.sv
// self-checking bench: register access, wake, status read, commands, strap modes
// assumes host_model on the line and the checker bound to the block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin fails++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module touch_key_link_tb;
  import touch_link_pkg::*;
  localparam int unsigned HT = 20;
  localparam logic [4:0] CNT [5] = '{5'h03, 5'h08, 5'h0c, 5'h01, 5'h10};
  localparam logic [1:0] CFG [5] = '{CFG_ONE, CFG_ONE, CFG_ANY, CFG_PIN, CFG_ALWAYS};
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  wb_req_t req = '0;
  wb_rsp_t rsp;
  logic [3:0] keys = 4'h0;
  logic [3:0] kout, d, cal;
  logic wake_pin = 1'b1;
  logic type_pin = 1'b1;
  logic line_o, line_oe, host_low, line_w, normal;
  logic [31:0] q;
  int fails = 0;
  int n_checks = 0;
  int cyc_n = 0;
  int n;
  // ****
  // wiring
  // ****
  assign line_w = !host_low && !(line_oe && !line_o);
  always #2 clk_i = ~clk_i;
  touch_key_link #(.HALF_LINE_DIV(HT), .MS_DIV(10)) u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_rsp_o(rsp), .key_det_i(keys),
    .wake_select_pin_i(wake_pin), .output_type_pin_i(type_pin), .shared_line_i(line_w),
    .shared_line_o(line_o), .shared_line_oe_o(line_oe), .key_out_o(kout),
    .cal_req_o(cal), .normal_mode_o(normal), .suspended_o());
  host_model #(.HT(HT)) u_host (.clk_i(clk_i), .line_i(line_w), .low_o(host_low));
  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    req <= '{cyc: 1'b1, stb: 1'b1, we: 1'b0, adr: a, sel: 4'hf, dat: 32'h0};
    do @(posedge clk_i); while (rsp.ack !== 1'b1);
    q = rsp.dat;
    req <= '0;
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_i);
    req <= '{cyc: 1'b1, stb: 1'b1, we: 1'b1, adr: a, sel: 4'hf, dat: v};
    do @(posedge clk_i); while (rsp.ack !== 1'b1);
    req <= '0;
  endtask : wr
  // strap pins change only while reset is held, as the block expects
  task automatic do_reset(input logic w, input logic t);
    rst_i <= 1'b1;
    wake_pin <= w;
    type_pin <= t;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (8) @(posedge clk_i);
  endtask : do_reset
  task automatic wrap_up();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : wrap_up
  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n == 30000) begin
      fails++;
      wrap_up();
    end
  end
  // ****
  // sequence
  // ****
  initial begin
    do_reset(1'b1, 1'b1);
    rd(REG_CTRL);
    `CHK(q, 32'h1)
    rd(REG_STATUS);
    `CHK(q, 32'h0)
    rd(8'h0c);
    `CHK(q, 32'h0)
    keys <= 4'h5;
    n = 0;
    while (normal !== 1'b1) begin
      @(posedge clk_i);
      n++;
    end
    `CHK(n inside {[3900:4200]}, 1'b1)
    // the other keys are only watched once awake, so a second debounce follows
    repeat (1200) @(posedge clk_i);
    while (line_oe === 1'b1) @(posedge clk_i);
    `CHK(kout, 4'h5)
    u_host.request();
    n = 0;
    fork
      u_host.read(d);
      while (line_oe !== 1'b1) begin
        @(posedge clk_i);
        n++;
      end
    join
    `CHK(d, 4'ha)
    `CHK(n inside {[50:70]}, 1'b1)
    while (line_oe === 1'b1) @(posedge clk_i);
    wr(REG_CTRL, 32'h0);
    rd(REG_CTRL);
    `CHK(q, 32'h0)
    u_host.request();
    repeat (100) @(posedge clk_i);
    `CHK(line_oe, 1'b0)
    wr(REG_CTRL, 32'h3);
    `CHK(cal, 4'hf)
    for (int i = 0; i < 5; i++) begin
      u_host.command(CNT[i]);
      repeat (12 * HT) @(posedge clk_i);
      rd(REG_STATUS);
      `CHK(q[10:9], CFG[i])
      rd(REG_CMD);
      `CHK(q[4:0], CNT[i])
    end
    do_reset(1'b0, 1'b0);
    rd(REG_STATUS);
    `CHK(q, 32'h1800)
    keys <= 4'h4;
    n = 0;
    while (normal !== 1'b1) begin
      @(posedge clk_i);
      n++;
    end
    `CHK(n inside {[3000:5000]}, 1'b1)
    keys <= 4'h0;
    repeat (1200) @(posedge clk_i);
    keys <= 4'h6;
    repeat (1200) @(posedge clk_i);
    `CHK(kout, 4'h2)
    do_reset(1'b1, 1'b1);
    `CHK(normal, 1'b0)
    u_host.command(16);
    repeat (12 * HT) @(posedge clk_i);
    `CHK(normal, 1'b1)
    wrap_up();
  end
endmodule : touch_key_link_tb
`default_nettype wire
